// ---- ial_pkg.sv ----
package ial_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] CFG_OFS    = 8'h00;
  localparam logic [7:0] PORTA_OFS  = 8'h04;
  localparam logic [7:0] PORTB_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;

  // ****************************************
  // Configuration word fields
  // ****************************************
  localparam int SW_POS     = 0;
  localparam int PROC_BIT   = 6;
  localparam int SAMP_BIT   = 7;
  localparam int OSTB_POS   = 8;
  localparam int LSTB_BIT   = 10;
  localparam int A_LAT_BIT  = 11;
  localparam int A_FLT_BIT  = 12;
  localparam int B_LAT_BIT  = 13;
  localparam int B_FLT_BIT  = 14;
  localparam int MAP_BIT    = 15;
  localparam int A_EXT_BIT  = 16;
  localparam int B_EXT_BIT  = 17;
  localparam logic [31:0] CFG_RESET = 32'h0000_7800;
  localparam logic [31:0] CFG_MASK  = 32'h0003_FFFF;

  // ****************************************
  // Address map
  // ****************************************
  localparam int PORT_W    = 24;
  localparam int ADDR_W    = 20;
  localparam int SPAN_BITS = 2;
  localparam int PAGE_SHIFT = 12;
  localparam logic [19:0] TURBO_BASE  = 20'h7_8C00;
  localparam logic [19:0] TURBO_SSTEP = 20'h0_0100;
  localparam logic [19:0] STN_BASE    = 20'h0_8800;
  localparam logic [19:0] STN_SSTEP   = 20'h0_0040;
  localparam logic [19:0] LEG_TEN     = 20'h0_FFE0;
  localparam logic [19:0] LEG_TWELVE  = 20'h0_FFE8;
  localparam logic [19:0] LEG_FOURTEEN = 20'h0_FFF0;

  typedef enum logic [1:0] {OSTB_INV, OSTB_TRUE, OSTB_OFF} ial_ostb_e;

endpackage

// ---- ial_sync.sv ----
`timescale 1ns/10ps
module ial_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // Two stages before any logic looks at a pin
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule // ial_sync

// ---- ial_port_latch.sv ----
`timescale 1ns/10ps
module ial_port_latch (
  input  wire logic                         clk_sys,
  input  wire logic                         srst,
  input  wire logic                         capture,
  input  wire logic [ial_pkg::PORT_W-1:0]   din,
  output logic      [ial_pkg::PORT_W-1:0]   dout
);

  logic [ial_pkg::PORT_W-1:0] word_reg;
  logic [ial_pkg::PORT_W-1:0] word_next;

  // Hold last capture while no strobe or port in fault
  always_comb begin
    word_next = word_reg;
    if (capture) begin
      word_next = din;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      word_reg <= '0;
    end else begin
      word_reg <= word_next;
    end
  end

  assign dout = word_reg;

endmodule // ial_port_latch

// ---- ial_top.sv ----
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/10ps
// What this block does
// - Switch positions 1,2 choose select line ten, twelve, fourteen or sixteen.
// - Turbo map: positions 3,4 pick page 78-7B, four addresses; 5,6 closed.
// - Station map: bases 8800 to B8C0, select offsets 00,40,80,C0 per page; processor jumper 2-3 puts last page ten-fourteen at FFE0, FFE8, FFF0.
// - After reset all switches closed: first page on select line ten.
// - Processor jumper 1-2 current processors, 2-3 older station processors.
// - Sample clock is servo clock in 1-2 (default), phase clock in 2-3.
// - Output strobe: inverted sample clock 1-2, true 2-3, off when removed.
// - Latch strobe: true sample clock 1-2 (default), inverted in 2-3.
// - Port A latch input triggers high when fitted, low when removed.
// - Port B latch input triggers high when fitted, low when removed.
// - Port A fault disables latch: low when fitted, high when removed.
// - Port B fault disables latch: low when fitted, high when removed.
// - Output strobe only for encoder sync, one pin, no other function.
// - Latch and fault inputs read high when the encoder supplies none.
module ial_top (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        servo_clock,
  input  wire logic        phase_clock,
  input  wire logic        port_a_latch_input,
  input  wire logic        port_a_fault_input,
  input  wire logic        port_b_latch_input,
  input  wire logic        port_b_fault_input,
  input  wire logic [23:0] port_a_data,
  input  wire logic [23:0] port_b_data,
  input  wire logic [3:0]  bp_select,
  input  wire logic [19:0] bp_addr,
  input  wire logic        bp_strobe,
  output logic             output_sample_strobe,
  output logic             output_sample_strobe_en,
  output logic             latch_enable_strobe,
  output logic [3:0]       board_select_line,
  output logic             bp_hit,
  output logic [23:0]      port_a_latched,
  output logic [23:0]      port_b_latched
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int SYNC_W = 79;

  logic [SYNC_W-1:0] pins_s;
  logic [19:0]       addr_s;
  logic              bstb_s;
  logic [3:0]        bsel_s;
  logic              servo_s;
  logic              phase_s;
  logic              a_lat_s;
  logic              a_flt_s;
  logic              b_lat_s;
  logic              b_flt_s;
  logic [23:0]       data_a_s;
  logic [23:0]       data_b_s;

  ial_sync #(.W(SYNC_W)) u_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .d       ({bp_addr, bp_strobe, bp_select, servo_clock, phase_clock,
                port_a_latch_input, port_a_fault_input,
                port_b_latch_input, port_b_fault_input,
                port_b_data, port_a_data}),
    .q       (pins_s)
  );

  assign {addr_s, bstb_s, bsel_s, servo_s, phase_s,
          a_lat_s, a_flt_s, b_lat_s, b_flt_s,
          data_b_s, data_a_s} = pins_s;

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic [19:0] base_addr(
    input logic       station,
    input logic       legacy,
    input logic [1:0] page,
    input logic [1:0] sel
  );
    logic [19:0] pg;
    pg = 20'(page) << ial_pkg::PAGE_SHIFT;
    if (!station) begin
      base_addr = ial_pkg::TURBO_BASE + pg
                  + 20'(ial_pkg::TURBO_SSTEP * sel);
    end else if (legacy && page == 2'h3 && sel != 2'h3) begin
      unique case (sel)
        2'h0:    base_addr = ial_pkg::LEG_TEN;
        2'h1:    base_addr = ial_pkg::LEG_TWELVE;
        default: base_addr = ial_pkg::LEG_FOURTEEN;
      endcase
    end else begin
      base_addr = ial_pkg::STN_BASE + pg
                  + 20'(ial_pkg::STN_SSTEP * sel);
    end
  endfunction

  // ****************************************
  // Configuration and Wishbone slave
  // ****************************************
  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic [31:0] status_w;
  logic [19:0] base_w;
  logic [1:0]  sel_idx;
  logic [1:0]  page_idx;
  logic        sw_valid;
  logic        req;

  assign sel_idx  = cfg_reg[ial_pkg::SW_POS +: 2];
  assign page_idx = cfg_reg[ial_pkg::SW_POS + 2 +: 2];
  // Positions 5 and 6 must stay closed
  assign sw_valid = (cfg_reg[ial_pkg::SW_POS + 4 +: 2] == 2'h0);
  assign base_w   = base_addr(cfg_reg[ial_pkg::MAP_BIT],
                              cfg_reg[ial_pkg::PROC_BIT],
                              page_idx, sel_idx);
  assign status_w = {7'h00, sw_valid, page_idx, sel_idx, base_w};
  assign req      = wb_cyc_i & wb_stb_i;

  always_comb begin
    cfg_next = cfg_reg;
    ack_next = req & ~ack_reg;
    dat_next = dat_reg;
    if (req & ~ack_reg) begin
      unique case (wb_adr_i)
        ial_pkg::CFG_OFS:    dat_next = cfg_reg;
        ial_pkg::PORTA_OFS:  dat_next = {8'h00, port_a_latched};
        ial_pkg::PORTB_OFS:  dat_next = {8'h00, port_b_latched};
        ial_pkg::STATUS_OFS: dat_next = status_w;
        default:             dat_next = 32'h0000_0000;
      endcase
    end
    // Write lands on the edge where the master sees ack
    if (req & ack_reg & wb_we_i & (wb_adr_i == ial_pkg::CFG_OFS)) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          cfg_next[8*i +: 8] = wb_dat_i[8*i +: 8];
        end
      end
      cfg_next = cfg_next & ial_pkg::CFG_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_reg <= ial_pkg::CFG_RESET;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      cfg_reg <= cfg_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ****************************************
  // Strobes, latch control, backplane hit
  // ****************************************
  ial_pkg::ial_ostb_e ostb_mode;
  logic samp;
  logic ostb_reg;
  logic ostb_next;
  logic oen_reg;
  logic oen_next;
  logic lstb_reg;
  logic lstb_next;
  logic [3:0] csel_reg;
  logic [3:0] csel_next;
  logic hit_reg;
  logic hit_next;
  logic a_lat_eff;
  logic a_flt_eff;
  logic b_lat_eff;
  logic b_flt_eff;
  logic a_active;
  logic b_active;
  logic a_dis;
  logic b_dis;
  logic rise;
  logic cap_a;
  logic cap_b;

  assign ostb_mode = ial_pkg::ial_ostb_e'(cfg_reg[ial_pkg::OSTB_POS +: 2]);

  always_comb begin
    samp = cfg_reg[ial_pkg::SAMP_BIT] ? phase_s : servo_s;
    ostb_next = 1'b0;
    oen_next  = 1'b0;
    // Only encoder sync; nothing else shares this pin
    unique case (ostb_mode)
      ial_pkg::OSTB_INV: begin
        ostb_next = ~samp;
        oen_next  = 1'b1;
      end
      ial_pkg::OSTB_TRUE: begin
        ostb_next = samp;
        oen_next  = 1'b1;
      end
      ial_pkg::OSTB_OFF: begin
        ostb_next = 1'b0;
        oen_next  = 1'b0;
      end
      default: begin
        ostb_next = 1'b0;
        oen_next  = 1'b0;
      end
    endcase
    lstb_next = cfg_reg[ial_pkg::LSTB_BIT] ? ~samp : samp;
    // Unused encoder signals read as pulled high
    a_lat_eff = cfg_reg[ial_pkg::A_EXT_BIT] ? a_lat_s : 1'b1;
    a_flt_eff = cfg_reg[ial_pkg::A_EXT_BIT] ? a_flt_s : 1'b1;
    b_lat_eff = cfg_reg[ial_pkg::B_EXT_BIT] ? b_lat_s : 1'b1;
    b_flt_eff = cfg_reg[ial_pkg::B_EXT_BIT] ? b_flt_s : 1'b1;
    a_active = cfg_reg[ial_pkg::A_LAT_BIT] ? a_lat_eff : ~a_lat_eff;
    b_active = cfg_reg[ial_pkg::B_LAT_BIT] ? b_lat_eff : ~b_lat_eff;
    a_dis = cfg_reg[ial_pkg::A_FLT_BIT] ? ~a_flt_eff : a_flt_eff;
    b_dis = cfg_reg[ial_pkg::B_FLT_BIT] ? ~b_flt_eff : b_flt_eff;
    rise  = lstb_next & ~lstb_reg;
    cap_a = rise & a_active & ~a_dis;
    cap_b = rise & b_active & ~b_dis;
    csel_next = sw_valid ? (4'h1 << sel_idx) : 4'h0;
    // Low address bits pick the word inside the board
    hit_next = sw_valid & bstb_s & |(bsel_s & csel_reg)
               & (addr_s[19:ial_pkg::SPAN_BITS]
                  == base_w[19:ial_pkg::SPAN_BITS]);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ostb_reg <= 1'b0;
      oen_reg  <= 1'b0;
      lstb_reg <= 1'b0;
      csel_reg <= 4'h0;
      hit_reg  <= 1'b0;
    end else begin
      ostb_reg <= ostb_next;
      oen_reg  <= oen_next;
      lstb_reg <= lstb_next;
      csel_reg <= csel_next;
      hit_reg  <= hit_next;
    end
  end

  assign output_sample_strobe    = ostb_reg;
  assign output_sample_strobe_en = oen_reg;
  assign latch_enable_strobe     = lstb_reg;
  assign board_select_line       = csel_reg;
  assign bp_hit                  = hit_reg;

  // ****************************************
  // Port latches
  // ****************************************
  ial_port_latch u_latch_a (
    .clk_sys (clk_sys),
    .srst    (srst),
    .capture (cap_a),
    .din     (data_a_s),
    .dout    (port_a_latched)
  );

  ial_port_latch u_latch_b (
    .clk_sys (clk_sys),
    .srst    (srst),
    .capture (cap_b),
    .din     (data_b_s),
    .dout    (port_b_latched)
  );

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_sel_ten: assert property (
    (!srst && cfg_reg[5:0] == 6'h00) ##1 (cfg_reg[5:0] == 6'h00) |-> csel_reg == 4'h1)
    else $error("select line ten not chosen with switches closed");

  a_sel_sixteen: assert property (
    (cfg_reg[5:0] == 6'h03) ##1 (cfg_reg[5:0] == 6'h03) |-> csel_reg == 4'h8)
    else $error("select line sixteen not chosen");

  a_turbo_page: assert property (
    (!cfg_reg[ial_pkg::MAP_BIT] && cfg_reg[5:0] == 6'h0D)
      |-> base_w == 20'h7_BD00)
    else $error("turbo page decode wrong");

  a_station_base: assert property (
    (cfg_reg[ial_pkg::MAP_BIT] && !cfg_reg[ial_pkg::PROC_BIT]
      && cfg_reg[5:0] == 6'h0F) |-> base_w == 20'h0_B8C0)
    else $error("station base decode wrong");

  a_legacy_alt: assert property (
    (cfg_reg[ial_pkg::MAP_BIT] && cfg_reg[ial_pkg::PROC_BIT]
      && cfg_reg[5:0] == 6'h0D) |-> base_w == 20'h0_FFE8)
    else $error("legacy alternate address wrong");

  a_reset_cfg: assert property (
    $fell(srst) |-> cfg_reg == ial_pkg::CFG_RESET && csel_reg == 4'h0)
    else $error("configuration not at assembly default after reset");

  a_ostb_off: assert property (
    (ostb_mode == ial_pkg::OSTB_OFF) ##1 (ostb_mode == ial_pkg::OSTB_OFF)
      |-> !output_sample_strobe_en && !output_sample_strobe)
    else $error("output strobe driven with jumper removed");

  a_ostb_inv: assert property (
    (!srst && ostb_mode == ial_pkg::OSTB_INV && !cfg_reg[ial_pkg::SAMP_BIT])
      |=> output_sample_strobe == !$past(servo_s))
    else $error("output strobe not inverted servo clock");

  a_lstb_true: assert property (
    (!cfg_reg[ial_pkg::LSTB_BIT] && cfg_reg[ial_pkg::SAMP_BIT])
      |=> latch_enable_strobe == $past(phase_s))
    else $error("latch strobe not true phase clock");

  a_fault_hold: assert property (
    a_dis |=> $stable(port_a_latched))
    else $error("port A updated while fault disables it");

  a_capture_b: assert property (
    cap_b |=> port_b_latched == $past(data_b_s))
    else $error("port B capture lost");

  a_hit_select: assert property (
    bp_hit |-> $past(bstb_s) && |($past(bsel_s) & $past(csel_reg)))
    else $error("backplane hit without select line");

  a_wb_ack: assert property (
    (req && !ack_reg) |=> ack_reg ##1 !ack_reg)
    else $error("ack not a single cycle answer");

  c_capture_a: cover property (cap_a ##1 port_a_latched != 24'h00_0000);
  c_bp_hit: cover property (bp_hit);
  c_cfg_write: cover property (req && ack_reg && wb_we_i);
  c_ostb_off: cover property (ostb_mode == ial_pkg::OSTB_OFF);

endmodule // ial_top

// ---- ial_ctrl_model.sv ----
`timescale 1ns/10ps
module ial_ctrl_model (
  input  wire logic        clk_sys,
  output logic             servo_clock,
  output logic             phase_clock,
  output logic [3:0]       bp_select,
  output logic [19:0]      bp_addr,
  output logic             bp_strobe
);
  // ****************************************
  // Controller side of the backplane
  // ****************************************
  initial begin
    servo_clock = 1'b0;
    phase_clock = 1'b0;
    bp_select = 4'h0;
    bp_addr = 20'h0_0000;
    bp_strobe = 1'b0;
  end

  task automatic set_clocks(input logic s, input logic p);
    servo_clock <= s;
    phase_clock <= p;
    @(posedge clk_sys);
  endtask

  // Long high and low phases so the edge survives the pin sync
  task automatic pulse_sample();
    set_clocks(1'b1, 1'b0);
    repeat (4) @(posedge clk_sys);
    set_clocks(1'b0, 1'b0);
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic access(input logic [3:0] sel, input logic [19:0] adr);
    bp_select <= sel;
    bp_addr <= adr;
    bp_strobe <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask

  // Released address lines float: show inverse of last value
  task automatic release_bus();
    bp_select <= 4'h0;
    bp_addr <= ~bp_addr;
    bp_strobe <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule // ial_ctrl_model

// ---- io_board_address_latch_cfg_tb_top.sv ----
`timescale 1ns/10ps
module io_board_address_latch_cfg_tb_top;
  logic        clk_sys, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, bp_select, board_select_line;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic        servo_clock, phase_clock, bp_strobe, bp_hit;
  logic        port_a_latch_input, port_a_fault_input;
  logic        port_b_latch_input, port_b_fault_input;
  logic        output_sample_strobe, output_sample_strobe_en, latch_enable_strobe;
  logic [19:0] bp_addr;
  logic [23:0] port_a_data, port_b_data, port_a_latched, port_b_latched;
  int          error_cnt = 0;
  int          num_checks = 0;

  ial_top i_ial_top (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .servo_clock(servo_clock), .phase_clock(phase_clock),
    .port_a_latch_input(port_a_latch_input), .port_a_fault_input(port_a_fault_input),
    .port_b_latch_input(port_b_latch_input), .port_b_fault_input(port_b_fault_input),
    .port_a_data(port_a_data), .port_b_data(port_b_data), .bp_select(bp_select),
    .bp_addr(bp_addr), .bp_strobe(bp_strobe), .output_sample_strobe(output_sample_strobe),
    .output_sample_strobe_en(output_sample_strobe_en),
    .latch_enable_strobe(latch_enable_strobe), .board_select_line(board_select_line),
    .bp_hit(bp_hit), .port_a_latched(port_a_latched), .port_b_latched(port_b_latched));

  ial_ctrl_model i_ial_ctrl_model (.clk_sys(clk_sys), .servo_clock(servo_clock),
    .phase_clock(phase_clock), .bp_select(bp_select), .bp_addr(bp_addr),
    .bp_strobe(bp_strobe));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Bounded wait so a missing ack cannot hang the run
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    chk({31'h0, wb_ack_o}, 32'h1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic drive_pulse(input logic [23:0] a, input logic [23:0] b,
                             input logic lat, input logic flt);
    port_a_data <= a;
    port_b_data <= b;
    port_a_latch_input <= lat;
    port_b_latch_input <= lat;
    port_a_fault_input <= flt;
    port_b_fault_input <= flt;
    repeat (4) @(posedge clk_sys);
    i_ial_ctrl_model.pulse_sample();
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    wb_xfer(1'b0, ial_pkg::CFG_OFS, 32'h0);
    chk(rdat, ial_pkg::CFG_RESET);
    wb_xfer(1'b0, ial_pkg::STATUS_OFS, 32'h0);
    chk(rdat, {12'h010, ial_pkg::TURBO_BASE});
    chk({28'h0, board_select_line}, 32'h1);
    wb_xfer(1'b1, 8'h10, 32'hFFFF_FFFF);
    wb_xfer(1'b1, ial_pkg::PORTA_OFS, 32'hFFFF_FFFF);
    wb_xfer(1'b0, 8'h10, 32'h0);
    chk(rdat, 32'h0);
    wb_xfer(1'b0, ial_pkg::CFG_OFS, 32'h0);
    chk(rdat, ial_pkg::CFG_RESET);
  endtask

  task automatic t_decode();
    logic [19:0] base;
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 4; p++) begin
        for (int s = 0; s < 4; s++) begin
          if (m == 0) base = ial_pkg::TURBO_BASE + (20'(p) << 12) + 20'(s) * ial_pkg::TURBO_SSTEP;
          else base = ial_pkg::STN_BASE + (20'(p) << 12) + 20'(s) * ial_pkg::STN_SSTEP;
          if (m == 2 && p == 3 && s < 3) base = ial_pkg::LEG_TEN + 20'(s * 8);
          wb_xfer(1'b1, ial_pkg::CFG_OFS,
                  32'h0000_7800 | (32'(m > 0) << 15) | (32'(m == 2) << 6) | 32'(p * 4 + s));
          wb_xfer(1'b0, ial_pkg::STATUS_OFS, 32'h0);
          chk(rdat, {7'h0, 1'b1, 2'(p), 2'(s), base});
          chk({28'h0, board_select_line}, 32'h1 << s);
          i_ial_ctrl_model.access(4'h1 << s, base + 20'h0_0003);
          chk({31'h0, bp_hit}, 32'h1);
          i_ial_ctrl_model.access(4'h1 << ((s + 1) % 4), base);
          chk({31'h0, bp_hit}, 32'h0);
          i_ial_ctrl_model.access(4'h1 << s, base + 20'h0_0004);
          chk({31'h0, bp_hit}, 32'h0);
          i_ial_ctrl_model.release_bus();
        end
      end
    end
    wb_xfer(1'b1, ial_pkg::CFG_OFS, 32'h0000_7830);
    repeat (3) @(posedge clk_sys);
    chk({28'h0, board_select_line}, 32'h0);
  endtask

  task automatic t_strobes();
    logic       samp;
    logic [1:0] om;
    for (int c = 0; c < 16; c++) begin
      om = 2'(c >> 1);
      // Mode 2 is the removed jumper used on third-party racks
      wb_xfer(1'b1, ial_pkg::CFG_OFS, 32'h0000_7800 | (32'(c & 1) << 7) | (32'(om) << 8)
              | (32'(c >> 3) << 10));
      for (int v = 0; v < 2; v++) begin
        i_ial_ctrl_model.set_clocks(1'(v), 1'(1 - v));
        repeat (4) @(posedge clk_sys);
        samp = ((c & 1) != 0) ? 1'(1 - v) : 1'(v);
        chk({31'h0, output_sample_strobe_en}, 32'(om < 2));
        chk({31'h0, output_sample_strobe},
            {31'h0, (om < 2) & (samp ^ (om == 0))});
        chk({31'h0, latch_enable_strobe}, {31'h0, samp ^ 1'(c >> 3)});
      end
    end
    i_ial_ctrl_model.set_clocks(1'b0, 1'b0);
  endtask

  task automatic t_latch();
    logic [23:0] ka, kb;
    for (int k = 0; k < 4; k++) begin
      wb_xfer(1'b1, ial_pkg::CFG_OFS, 32'h0003_0000 | (32'(k & 1) * 32'h0000_2800)
              | (32'(k >> 1) * 32'h0000_5000));
      ka = 24'h5A_0000 | 24'(k);
      kb = 24'hA5_0000 | 24'(k);
      drive_pulse(ka, kb, 1'(k & 1), 1'(k >> 1));
      chk({8'h0, port_a_latched}, {8'h0, ka});
      chk({8'h0, port_b_latched}, {8'h0, kb});
      drive_pulse(~ka, ~kb, 1'(k & 1), 1'(1 - (k >> 1)));
      chk({8'h0, port_a_latched}, {8'h0, ka});
      chk({8'h0, port_b_latched}, {8'h0, kb});
      drive_pulse(~ka, ~kb, 1'(1 - (k & 1)), 1'(k >> 1));
      chk({8'h0, port_a_latched}, {8'h0, ka});
      chk({8'h0, port_b_latched}, {8'h0, kb});
    end
    wb_xfer(1'b0, ial_pkg::PORTA_OFS, 32'h0);
    chk(rdat, 32'h005A_0003);
    wb_xfer(1'b1, ial_pkg::CFG_OFS, ial_pkg::CFG_RESET);
    drive_pulse(24'h12_3456, 24'h65_4321, 1'b0, 1'b0);
    chk({8'h0, port_a_latched}, 32'h0012_3456);
    chk({8'h0, port_b_latched}, 32'h0065_4321);
  endtask

  // ****************************************
  // Clock, reset, sequence, watchdog
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    srst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    {port_a_latch_input, port_a_fault_input} = 2'h0;
    {port_b_latch_input, port_b_fault_input} = 2'h0;
    port_a_data = 24'h00_0000;
    port_b_data = 24'h00_0000;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_decode();
    t_strobes();
    t_latch();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    end_sim();
  end
endmodule // io_board_address_latch_cfg_tb_top
